/* File: hw/smd_datapath.sv */
// Notes on behaviour
// - shift left moves bit 7 to carry, bits 6:0 up, zero in bit 0.
// - shift right puts zero in bit 7, bits 7:1 down, bit 0 to carry.
// - destination select 0 writes the accumulator, 1 writes the file.
// - move copies file register 0..127 unchanged; carry stays untouched.
// - move updates zero flag, so move to itself tests the register.
module smd_datapath #(
  parameter int DATA_W = smd_pkg::DATA_W,
  parameter int ADDR_W = smd_pkg::ADDR_W
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  // operation issue
  input wire logic i_op_valid,
  input wire logic [1:0] i_op,
  input wire logic [ADDR_W-1:0] i_file_addr,
  input wire logic i_dest_sel,
  // host write port into the file registers, used when idle
  input wire logic i_host_wr_en,
  input wire logic [ADDR_W-1:0] i_host_wr_addr,
  input wire logic [DATA_W-1:0] i_host_wr_data,
  // results and status
  output logic [DATA_W-1:0] o_accum,
  output logic o_carry,
  output logic o_zero,
  output logic o_done,
  output logic [DATA_W-1:0] o_result
);
  // ------------------------------------------------------------
  // parameter checks
  // ------------------------------------------------------------
  // refused at elaboration: the shift and zero logic assume one byte
  if (DATA_W != 8) begin
    $error("smd_datapath: data width must be 8");
  end
  if (ADDR_W < 1 || ADDR_W > 7) begin
    $error("smd_datapath: address width must be 1 to 7");
  end

  // ------------------------------------------------------------
  // sequencer: issue reads the operand, exec applies the result
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    SMD_IDLE = 2'b01,
    SMD_EXEC = 2'b10
  } smd_state_t;

  smd_state_t state_q;
  logic [1:0] op_q;
  logic [ADDR_W-1:0] addr_q;
  logic dest_q;
  logic [DATA_W-1:0] operand;
  logic [DATA_W-1:0] result;
  logic carry_out;
  logic carry_upd;
  logic exec;
  logic file_we;
  logic [ADDR_W-1:0] file_waddr;
  logic [DATA_W-1:0] file_wdata;

  assign exec = (state_q == SMD_EXEC);

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      state_q <= SMD_IDLE;
    end else begin
      case (state_q)
        SMD_IDLE: begin
          if (i_op_valid && i_op != smd_pkg::OP_NONE) begin
            state_q <= SMD_EXEC;
          end
        end
        SMD_EXEC: begin
          state_q <= SMD_IDLE;
        end
        default: begin
          state_q <= SMD_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      op_q <= smd_pkg::OP_NONE;
      addr_q <= '0;
      dest_q <= smd_pkg::DEST_ACCUM;
    end else if (state_q == SMD_IDLE && i_op_valid) begin
      op_q <= i_op;
      addr_q <= i_file_addr;
      dest_q <= i_dest_sel;
    end
  end

  // ------------------------------------------------------------
  // file registers
  // ------------------------------------------------------------
  // operation write-back has priority; host writes are only taken idle
  assign file_we = (exec && dest_q == smd_pkg::DEST_FILE) ||
                   (!exec && i_host_wr_en);
  assign file_waddr = exec ? addr_q : i_host_wr_addr;
  assign file_wdata = exec ? result : i_host_wr_data;

  smd_file_mem #(
    .DATA_W(DATA_W),
    .ADDR_W(ADDR_W)
  ) u_file (
    .i_ref_clk(i_ref_clk),
    .i_rd_addr(i_file_addr),
    .o_rd_data(operand),
    .i_wr_en(file_we),
    .i_wr_addr(file_waddr),
    .i_wr_data(file_wdata)
  );

  // ------------------------------------------------------------
  // result logic
  // ------------------------------------------------------------
  function automatic logic is_zero(input logic [7:0] v);
    return v == 8'h00;
  endfunction

  always_comb begin
    result = operand;
    carry_out = o_carry;
    carry_upd = 1'b0;
    case (op_q)
      smd_pkg::OP_LOGICAL_SHIFT_LEFT: begin
        result = {operand[6:0], 1'b0};
        carry_out = operand[7];
        carry_upd = 1'b1;
      end
      smd_pkg::OP_LOGICAL_SHIFT_RIGHT: begin
        result = {1'b0, operand[7:1]};
        carry_out = operand[0];
        carry_upd = 1'b1;
      end
      smd_pkg::OP_MOVE_FILE: begin
        result = operand;
        carry_upd = 1'b0;
      end
      default: begin
        result = operand;
      end
    endcase
  end

  // ------------------------------------------------------------
  // architectural state
  // ------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      o_accum <= smd_pkg::ACCUM_RESET;
    end else if (exec && dest_q == smd_pkg::DEST_ACCUM) begin
      o_accum <= result;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      o_carry <= smd_pkg::FLAG_RESET;
    end else if (exec && carry_upd) begin
      o_carry <= carry_out;
    end
  end

  // every operation here touches the zero flag, move included
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      o_zero <= smd_pkg::FLAG_RESET;
    end else if (exec) begin
      o_zero <= is_zero(result);
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      o_done <= 1'b0;
      o_result <= '0;
    end else begin
      o_done <= exec;
      if (exec) begin
        o_result <= result;
      end
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  logic [DATA_W-1:0] operand_seen_q;
  always_ff @(posedge i_ref_clk) begin
    operand_seen_q <= operand;
  end

  chk_shl_result: assert property (
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    exec && op_q == smd_pkg::OP_LOGICAL_SHIFT_LEFT |=>
      o_result == {operand_seen_q[6:0], 1'b0} &&
      o_carry == operand_seen_q[7])
    else $error("shift left result or carry wrong");

  chk_shr_result: assert property (
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    exec && op_q == smd_pkg::OP_LOGICAL_SHIFT_RIGHT |=>
      o_result == {1'b0, operand_seen_q[7:1]} &&
      o_carry == operand_seen_q[0])
    else $error("shift right result or carry wrong");

  chk_dest_accum: assert property (
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    exec && dest_q == smd_pkg::DEST_ACCUM |=> o_accum == o_result)
    else $error("accumulator not written");

  chk_dest_file: assert property (
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    exec && dest_q == smd_pkg::DEST_FILE |=> $stable(o_accum))
    else $error("accumulator changed on file destination");

  chk_move_carry: assert property (
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    exec && op_q == smd_pkg::OP_MOVE_FILE |=>
      $stable(o_carry) && o_result == operand_seen_q)
    else $error("move altered carry or data");

  chk_zero_flag: assert property (
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    o_done |-> o_zero == (o_result == 8'h00))
    else $error("zero flag mismatch");

  chk_move_zero: assert property (
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    exec && op_q == smd_pkg::OP_MOVE_FILE && operand == 8'h00 |=>
      o_zero)
    else $error("move of zero did not set zero flag");

  chk_done_timing: assert property (
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    state_q == SMD_IDLE && i_op_valid && i_op != smd_pkg::OP_NONE
      |=> ##1 o_done)
    else $error("done not two cycles after issue");

  cov_shl: cover property (@(posedge i_ref_clk)
    exec && op_q == smd_pkg::OP_LOGICAL_SHIFT_LEFT);
  cov_shr_file: cover property (@(posedge i_ref_clk)
    exec && op_q == smd_pkg::OP_LOGICAL_SHIFT_RIGHT && dest_q);
  cov_move_zero: cover property (@(posedge i_ref_clk)
    exec && op_q == smd_pkg::OP_MOVE_FILE && operand == 8'h00);
endmodule

/* File: hw/smd_pkg.sv */
package smd_pkg;
  // operation codes presented on the op input
  localparam logic [1:0] OP_NONE = 2'h0;
  localparam logic [1:0] OP_LOGICAL_SHIFT_LEFT = 2'h1;
  localparam logic [1:0] OP_LOGICAL_SHIFT_RIGHT = 2'h2;
  localparam logic [1:0] OP_MOVE_FILE = 2'h3;
  // destination select values
  localparam logic DEST_ACCUM = 1'h0;
  localparam logic DEST_FILE = 1'h1;
  // widths and reset values
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam int FILE_DEPTH = 128;
  localparam logic [7:0] ACCUM_RESET = 8'h00;
  localparam logic FLAG_RESET = 1'h0;
  // operation timing: result and done come two cycles after issue; OP_LATENCY is not used by the datapath
  localparam int OP_LATENCY = 1;
endpackage

/* File: hw/smd_file_mem.sv */
module smd_file_mem #(
  parameter int DATA_W = 8,
  parameter int ADDR_W = 7
) (
  // clock
  input wire logic i_ref_clk,
  // read port
  input wire logic [ADDR_W-1:0] i_rd_addr,
  output logic [DATA_W-1:0] o_rd_data,
  // write port
  input wire logic i_wr_en,
  input wire logic [ADDR_W-1:0] i_wr_addr,
  input wire logic [DATA_W-1:0] i_wr_data
);
  logic [DATA_W-1:0] mem_q [2**ADDR_W];

  // file contents are not reset, as on the real register file
  always_ff @(posedge i_ref_clk) begin
    if (i_wr_en) begin
      mem_q[i_wr_addr] <= i_wr_data;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    o_rd_data <= mem_q[i_rd_addr];
  end
endmodule

/* File: verif/tb_top.sv */
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_ref_clk, i_reset_n, i_op_valid, i_dest_sel, i_host_wr_en;
  logic [1:0] i_op;
  logic [6:0] i_file_addr, i_host_wr_addr;
  logic [7:0] i_host_wr_data, o_accum, o_result;
  logic o_carry, o_zero, o_done;
  int n_mismatch = 0;
  int tests_run = 0;
  // bench's own view of the architectural state, kept from the rules
  logic exp_carry = smd_pkg::FLAG_RESET;
  logic [7:0] exp_accum = smd_pkg::ACCUM_RESET;

  smd_datapath i_dut (
    .i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n),
    .i_op_valid(i_op_valid), .i_op(i_op),
    .i_file_addr(i_file_addr), .i_dest_sel(i_dest_sel),
    .i_host_wr_en(i_host_wr_en), .i_host_wr_addr(i_host_wr_addr),
    .i_host_wr_data(i_host_wr_data), .o_accum(o_accum),
    .o_carry(o_carry), .o_zero(o_zero), .o_done(o_done),
    .o_result(o_result)
  );

  initial begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end

  // ------------------------------------------------------------
  // checking and ending
  // ------------------------------------------------------------
  task automatic chk_byte(input string what, input logic [7:0] exp,
                          input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp,
                         input logic got);
    chk_byte(what, {7'h00, exp}, {7'h00, got});
  endtask

  task automatic end_of_test();
    $display("mismatches %0d, checks %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ------------------------------------------------------------
  // drivers: inputs change on the falling edge only
  // ------------------------------------------------------------
  task automatic do_op(input logic [1:0] op, input logic [6:0] a,
                       input logic d);
    int n;
    n = 0;
    @(negedge i_ref_clk);
    i_op_valid = 1'b1;
    i_op = op;
    i_file_addr = a;
    i_dest_sel = d;
    @(negedge i_ref_clk);
    i_op_valid = 1'b0;
    i_op = smd_pkg::OP_NONE;
    while (o_done !== 1'b1 && n < 4) begin
      @(negedge i_ref_clk);
      n++;
    end
    chk_bit("done", 1'h1, o_done);
  endtask

  // preload, run one op, then read the file back when it was the target
  task automatic op_test(input logic [1:0] op, input logic [6:0] a,
                         input logic d, input logic [7:0] f);
    logic [7:0] r, acc0;
    logic c;
    @(negedge i_ref_clk);
    i_host_wr_en = 1'b1;
    i_host_wr_addr = a;
    i_host_wr_data = f;
    @(negedge i_ref_clk);
    i_host_wr_en = 1'b0;
    c = exp_carry;
    acc0 = exp_accum;
    r = f;
    if (op == smd_pkg::OP_LOGICAL_SHIFT_LEFT) begin
      r = {f[6:0], 1'h0};
      c = f[7];
    end else if (op == smd_pkg::OP_LOGICAL_SHIFT_RIGHT) begin
      r = {1'h0, f[7:1]};
      c = f[0];
    end
    do_op(op, a, d);
    chk_byte("result", r, o_result);
    chk_bit("carry", c, o_carry);
    chk_bit("zero", r == 8'h00, o_zero);
    chk_byte("accum", d ? acc0 : r, o_accum);
    exp_carry = c;
    exp_accum = d ? acc0 : r;
    @(negedge i_ref_clk);
    chk_bit("done low", 1'h0, o_done);
    if (d) begin
      do_op(smd_pkg::OP_MOVE_FILE, a, smd_pkg::DEST_ACCUM);
      chk_byte("file", r, o_accum);
      exp_accum = r;
    end
  endtask

  // an issue or host write during exec is ignored, as is op none
  task automatic t_refused();
    @(negedge i_ref_clk);
    i_host_wr_en = 1'b1;
    i_host_wr_addr = 7'h40;
    i_host_wr_data = 8'h03;
    @(negedge i_ref_clk);
    i_host_wr_en = 1'b0;
    i_op_valid = 1'b1;
    i_op = smd_pkg::OP_LOGICAL_SHIFT_LEFT;
    i_file_addr = 7'h40;
    i_dest_sel = smd_pkg::DEST_ACCUM;
    @(negedge i_ref_clk);
    i_op = smd_pkg::OP_LOGICAL_SHIFT_RIGHT;
    i_host_wr_en = 1'b1;
    i_host_wr_data = 8'hFF;
    @(negedge i_ref_clk);
    i_op = smd_pkg::OP_NONE;
    i_host_wr_en = 1'b0;
    chk_bit("done", 1'h1, o_done);
    chk_byte("result", 8'h06, o_result);
    chk_byte("accum", 8'h06, o_accum);
    chk_bit("carry", 1'h0, o_carry);
    chk_bit("zero", 1'h0, o_zero);
    @(negedge i_ref_clk);
    i_op_valid = 1'b0;
    chk_bit("done low", 1'h0, o_done);
    repeat (2) @(negedge i_ref_clk);
    chk_bit("no op", 1'h0, o_done);
    chk_byte("accum kept", 8'h06, o_accum);
    do_op(smd_pkg::OP_MOVE_FILE, 7'h40, smd_pkg::DEST_ACCUM);
    chk_byte("file kept", 8'h03, o_accum);
    chk_bit("carry kept", 1'h0, o_carry);
    exp_accum = 8'h03;
    exp_carry = 1'h0;
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_shift_left();
    op_test(smd_pkg::OP_LOGICAL_SHIFT_LEFT, 7'h00, 1'h0, 8'h81);
    op_test(smd_pkg::OP_LOGICAL_SHIFT_LEFT, 7'h7F, 1'h1, 8'h80);
    op_test(smd_pkg::OP_LOGICAL_SHIFT_LEFT, 7'h05, 1'h0, 8'h40);
  endtask

  task automatic t_shift_right();
    op_test(smd_pkg::OP_LOGICAL_SHIFT_RIGHT, 7'h10, 1'h0, 8'h01);
    op_test(smd_pkg::OP_LOGICAL_SHIFT_RIGHT, 7'h11, 1'h1, 8'hFE);
  endtask

  // carry is set first so an untouched carry can be told apart
  task automatic t_move();
    op_test(smd_pkg::OP_LOGICAL_SHIFT_LEFT, 7'h20, 1'h0, 8'hC0);
    op_test(smd_pkg::OP_MOVE_FILE, 7'h7F, 1'h1, 8'h00);
    op_test(smd_pkg::OP_MOVE_FILE, 7'h30, 1'h1, 8'hA5);
    op_test(smd_pkg::OP_MOVE_FILE, 7'h01, 1'h0, 8'h5A);
  endtask

  initial begin
    #50000;
    n_mismatch++;
    end_of_test();
  end

  initial begin
    i_reset_n = 1'b0;
    i_op_valid = 1'b0;
    i_op = smd_pkg::OP_NONE;
    i_file_addr = 7'h00;
    i_dest_sel = smd_pkg::DEST_ACCUM;
    i_host_wr_en = 1'b0;
    i_host_wr_addr = 7'h00;
    i_host_wr_data = 8'h00;
    repeat (4) @(negedge i_ref_clk);
    i_reset_n = 1'b1;
    chk_byte("accum reset", smd_pkg::ACCUM_RESET, o_accum);
    chk_bit("done reset", 1'h0, o_done);
    t_shift_left();
    t_shift_right();
    t_move();
    t_refused();
    end_of_test();
  end
endmodule
